// file: doc_pkg.sv
// Package for the DAC output calibration block
package doc_pkg;
    localparam int          DOC_CHANNELS     = 16;
    localparam logic [15:0] DOC_UNLOCK_KEY   = 16'h5e2a;
    localparam logic [15:0] DOC_LOCK_VALUE   = 16'h0000;
    localparam logic [15:0] DOC_IDEAL_ZERO   = 16'h0000;
    localparam logic [15:0] DOC_IDEAL_SPAN   = 16'h4e20;
    localparam logic [15:0] DOC_KEY_RESET    = 16'h0000;
    localparam logic [15:0] DOC_ZERO_RESET   = 16'h0000;
    localparam logic [15:0] DOC_SPAN_RESET   = 16'h4e20;
    localparam logic [1:0]  DOC_REG_KEY      = 2'h0;
    localparam logic [1:0]  DOC_REG_ZERO     = 2'h1;
    localparam logic [1:0]  DOC_REG_SPAN     = 2'h2;

    // Host register write carrier
    typedef struct packed {
        logic        valid;
        logic [1:0]  sel;
        logic [15:0] data;
    } doc_wr_t;

    // Browser calibration states
    typedef enum logic [2:0] {
        DOC_IDLE = 3'b001,
        DOC_HOLD = 3'b010,
        DOC_CAL  = 3'b100
    } doc_state_t;
endpackage : doc_pkg

// file: doc_dac_output_calibration.sv
// DAC output calibration control: unlock key, triggers, browser sequence
`timescale 1ns/1ps
module doc_dac_output_calibration
    import doc_pkg::*;
#(
    parameter int NCH = DOC_CHANNELS
)(
    // Clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  sys_rst_i,
    // Host register writes and output count words
    input  wire doc_pkg::doc_wr_t      host_wr_i,
    input  wire logic [NCH*16-1:0]     out_count_i,
    // Browser calibration controls
    input  wire logic                  web_set_i,
    input  wire logic                  web_span_i,
    input  wire logic [3:0]            web_chan_i,
    input  wire logic                  web_cal_i,
    input  wire logic                  web_restart_i,
    input  wire logic signed [15:0]    meter_measured_value_i,
    // DAC and calibration state
    output logic [NCH*16-1:0]          dac_count_o,
    output logic [NCH*16-1:0]          cal_zero_o,
    output logic [NCH*16-1:0]          cal_span_o,
    output logic                       unlocked_o,
    output logic                       web_busy_o
);
    import doc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [15:0]      key_ff, nxt_key;
    logic [15:0]      zero_ff [NCH];
    logic [15:0]      nxt_zero [NCH];
    logic [15:0]      span_ff [NCH];
    logic [15:0]      nxt_span [NCH];
    logic [15:0]      dac_ff [NCH];
    logic [15:0]      nxt_dac [NCH];
    doc_state_t       st_ff, nxt_st;
    logic [3:0]       ch_ff, nxt_ch;
    logic             sp_ff, nxt_sp;
    logic             unl;

    // Signed interpolation between endpoints, count scaled to base span
    function automatic logic [15:0] doc_interp(input logic [15:0] cnt,
                                               input logic [15:0] lo,
                                               input logic [15:0] hi);
        logic signed [47:0] prod;
        prod = 48'(signed'(cnt)) * (48'(signed'(hi)) - 48'(signed'(lo)));
        return 16'(prod / 48'(signed'(DOC_IDEAL_SPAN)) + 48'(signed'(lo)));
    endfunction : doc_interp

    assign unl = (key_ff == DOC_UNLOCK_KEY);

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        nxt_key = key_ff;
        nxt_st  = st_ff;
        nxt_ch  = ch_ff;
        nxt_sp  = sp_ff;
        for (int i = 0; i < NCH; i++)
        begin
            nxt_zero[i] = zero_ff[i];
            nxt_span[i] = span_ff[i];
            // Normal path: signed count mapped via endpoints
            nxt_dac[i]  = doc_interp(out_count_i[i*16 +: 16], zero_ff[i], span_ff[i]);
        end
        // Key register; zero relocks
        if (host_wr_i.valid && host_wr_i.sel == DOC_REG_KEY)
            nxt_key = host_wr_i.data;
        // Triggers capture raw DAC count, applied at once
        if (host_wr_i.valid && unl)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (host_wr_i.data[i] && host_wr_i.sel == DOC_REG_ZERO)
                    nxt_zero[i] = dac_ff[i];
                if (host_wr_i.data[i] && host_wr_i.sel == DOC_REG_SPAN)
                    nxt_span[i] = dac_ff[i];
            end
        end
        // Browser sequence
        case (st_ff)
            DOC_IDLE:
            begin
                if (web_set_i && int'(web_chan_i) < NCH)
                begin
                    nxt_st = DOC_HOLD;
                    nxt_ch = web_chan_i;
                    nxt_sp = web_span_i;
                end
            end
            DOC_HOLD:
            begin
                if (web_restart_i)
                    nxt_st = DOC_IDLE;
                else if (web_cal_i)
                    nxt_st = DOC_CAL;
            end
            DOC_CAL:
            begin
                // Correct ideal count by meter error
                if (sp_ff)
                    nxt_span[ch_ff] = 16'(DOC_IDEAL_SPAN + DOC_IDEAL_SPAN
                                          - meter_measured_value_i);
                else
                    nxt_zero[ch_ff] = 16'(DOC_IDEAL_ZERO + DOC_IDEAL_ZERO
                                          - meter_measured_value_i);
                nxt_st = DOC_IDLE;
            end
            default: nxt_st = DOC_IDLE;
        endcase
        // Held output takes over the channel
        if (st_ff != DOC_IDLE)
            nxt_dac[ch_ff] = sp_ff ? DOC_IDEAL_SPAN : DOC_IDEAL_ZERO;
        if (nxt_st == DOC_HOLD && st_ff == DOC_IDLE)
            nxt_dac[nxt_ch] = nxt_sp ? DOC_IDEAL_SPAN : DOC_IDEAL_ZERO;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            key_ff <= DOC_KEY_RESET;
            st_ff  <= DOC_IDLE;
            ch_ff  <= 4'h0;
            sp_ff  <= 1'b0;
            for (int i = 0; i < NCH; i++)
            begin
                zero_ff[i] <= DOC_ZERO_RESET;
                span_ff[i] <= DOC_SPAN_RESET;
                dac_ff[i]  <= DOC_IDEAL_ZERO;
            end
        end
        else
        begin
            key_ff <= nxt_key;
            st_ff  <= nxt_st;
            ch_ff  <= nxt_ch;
            sp_ff  <= nxt_sp;
            for (int i = 0; i < NCH; i++)
            begin
                zero_ff[i] <= nxt_zero[i];
                span_ff[i] <= nxt_span[i];
                dac_ff[i]  <= nxt_dac[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            dac_count_o[i*16 +: 16] = dac_ff[i];
            cal_zero_o[i*16 +: 16]  = zero_ff[i];
            cal_span_o[i*16 +: 16]  = span_ff[i];
        end
    end
    assign unlocked_o = unl;
    assign web_busy_o = (st_ff != DOC_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    AST_LOCKED_ZERO: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (!unl && st_ff == DOC_IDLE) |=> $stable(cal_zero_o))
        else $error("zero endpoint changed while locked");
    AST_LOCKED_SPAN: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (!unl && st_ff == DOC_IDLE) |=> $stable(cal_span_o))
        else $error("span endpoint changed while locked");
    AST_UNLOCK: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (host_wr_i.valid && host_wr_i.sel == DOC_REG_KEY && host_wr_i.data == DOC_UNLOCK_KEY)
        |=> unlocked_o)
        else $error("key did not unlock");
    AST_RELOCK: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (host_wr_i.valid && host_wr_i.sel == DOC_REG_KEY && host_wr_i.data == DOC_LOCK_VALUE)
        |=> !unlocked_o)
        else $error("zero write did not relock");
    AST_ZERO_CAP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (unl && st_ff == DOC_IDLE && host_wr_i.valid && host_wr_i.sel == DOC_REG_ZERO
         && host_wr_i.data[0]) |=> cal_zero_o[15:0] == $past(dac_count_o[15:0]))
        else $error("zero capture wrong");
    AST_SPAN_CAP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (unl && st_ff == DOC_IDLE && host_wr_i.valid && host_wr_i.sel == DOC_REG_SPAN
         && host_wr_i.data[0]) |=> cal_span_o[15:0] == $past(dac_count_o[15:0]))
        else $error("span capture wrong");
    AST_WEB_SPAN: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (st_ff == DOC_IDLE && web_set_i && web_span_i && int'(web_chan_i) < NCH)
        |=> dac_count_o[int'(ch_ff)*16 +: 16] == DOC_IDEAL_SPAN)
        else $error("ideal span not loaded");
    AST_WEB_ZERO: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (st_ff == DOC_IDLE && web_set_i && !web_span_i && int'(web_chan_i) < NCH)
        |=> dac_count_o[int'(ch_ff)*16 +: 16] == DOC_IDEAL_ZERO)
        else $error("ideal zero not loaded");
    AST_RESTART: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (st_ff == DOC_HOLD && web_restart_i) |=> !web_busy_o)
        else $error("restart did not release output");
endmodule : doc_dac_output_calibration

// file: doc_host_model.sv
// Host and meter model for the calibration block
`timescale 1ns/1ps
module doc_host_model (
    // Clock
    input  wire logic             clock_i,
    // Register writes and meter reading
    output doc_pkg::doc_wr_t      host_wr_o,
    output logic signed [15:0]    meter_o
);
    import doc_pkg::*;

    // Idle bus at time zero
    initial
    begin
        host_wr_o = '0;
        meter_o   = 16'sh0000;
    end

    // One write held across one rising edge; released fields show inverted data
    task automatic write_reg(input logic [1:0] sel, input logic [15:0] data);
        @(negedge clock_i);
        host_wr_o = {1'b1, sel, data};
        @(negedge clock_i);
        host_wr_o = {1'b0, ~sel, ~data};
    endtask : write_reg

    // Meter reading entered by the operator
    task automatic set_meter(input logic signed [15:0] v);
        meter_o = v;
    endtask : set_meter
endmodule : doc_host_model

// file: dac_output_calibration_test.sv
// Self-checking bench for the DAC output calibration block
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("Error %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module dac_output_calibration_test;
    import doc_pkg::*;
    logic                clk;
    logic                rst;
    logic                web_set;
    logic                web_span;
    logic                web_cal;
    logic                web_restart;
    logic [3:0]          web_chan;
    logic [255:0]        out_count;
    logic [255:0]        dac;
    logic [255:0]        cz;
    logic [255:0]        cs;
    logic                unlocked;
    logic                busy;
    doc_wr_t             host_wr;
    logic signed [15:0]  meter;
    int                  failures;
    int                  check_count;
    int                  cycles;

    doc_host_model u_doc_host_model (.clock_i(clk), .host_wr_o(host_wr), .meter_o(meter));
    doc_dac_output_calibration u_doc_dac_output_calibration (
        .clock_i(clk), .sys_rst_i(rst), .host_wr_i(host_wr), .out_count_i(out_count),
        .web_set_i(web_set), .web_span_i(web_span), .web_chan_i(web_chan),
        .web_cal_i(web_cal), .web_restart_i(web_restart), .meter_measured_value_i(meter),
        .dac_count_o(dac), .cal_zero_o(cz), .cal_span_o(cs), .unlocked_o(unlocked),
        .web_busy_o(busy));

    function automatic logic [15:0] sl(input logic [255:0] v, input int n);
        return v[n*16 +: 16];
    endfunction : sl

    // Output settling time before reading or triggering
    task automatic settle();
        repeat (4) @(negedge clk);
    endtask : settle

    // Browser buttons {set, calibrate, restart} pressed for one cycle
    task automatic press(input logic [2:0] btn);
        @(negedge clk);
        {web_set, web_cal, web_restart} = btn;
        @(negedge clk);
        {web_set, web_cal, web_restart} = 3'h0;
        settle();
    endtask : press

    task automatic print_verdict();
        $display("Checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    // Clock of 25 ns period
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            print_verdict();
        end
    end

    // Main sequence; only base-range counts are driven
    initial
    begin
        {rst, web_set, web_span, web_cal, web_restart} = 5'h10;
        web_chan  = 4'h3;
        out_count = '0; // Base range assumed selected
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        `CHK(unlocked, 1'b0)
        `CHK(sl(cs, 0), DOC_SPAN_RESET)
        out_count[15:0]  = 16'h0064;
        out_count[47:32] = 16'hff9c;
        settle();
        `CHK(sl(dac, 0), 16'h0064)
        `CHK(sl(dac, 2), 16'hff9c)
        u_doc_host_model.write_reg(DOC_REG_ZERO, 16'h0001);
        settle();
        `CHK(sl(cz, 0), 16'h0000)
        u_doc_host_model.write_reg(DOC_REG_KEY, DOC_UNLOCK_KEY);
        `CHK(unlocked, 1'b1)
        u_doc_host_model.write_reg(DOC_REG_ZERO, 16'h0001);
        settle();
        `CHK(sl(cz, 0), 16'h0064)
        `CHK(sl(cz, 1), 16'h0000)
        out_count[15:0] = 16'h0000;
        settle();
        `CHK(sl(dac, 0), 16'h0064)
        out_count[15:0] = 16'h4a38;
        settle();
        `CHK(sl(dac, 0), 16'h4a3d)
        u_doc_host_model.write_reg(DOC_REG_SPAN, 16'h0001);
        settle();
        `CHK(sl(cs, 0), 16'h4a3d)
        u_doc_host_model.write_reg(DOC_REG_KEY, DOC_LOCK_VALUE);
        `CHK(unlocked, 1'b0)
        out_count[15:0] = 16'h0100;
        u_doc_host_model.write_reg(DOC_REG_SPAN, 16'h0001);
        settle();
        `CHK(sl(cs, 0), 16'h4a3d)
        press(3'h4);
        `CHK(busy, 1'b1)
        `CHK(sl(dac, 3), DOC_IDEAL_ZERO)
        out_count[63:48] = 16'h01f4;
        settle();
        `CHK(sl(dac, 3), DOC_IDEAL_ZERO)
        u_doc_host_model.set_meter(16'sh0005);
        press(3'h2);
        `CHK(sl(cz, 3), 16'hfffb)
        `CHK(busy, 1'b0)
        web_span = 1'b1;
        press(3'h4);
        `CHK(sl(dac, 3), DOC_IDEAL_SPAN)
        // A second set while the sequence is held must be refused
        web_chan = 4'h4;
        press(3'h4);
        `CHK(busy, 1'b1)
        `CHK(sl(dac, 3), DOC_IDEAL_SPAN)
        press(3'h1);
        `CHK(busy, 1'b0)
        `CHK(sl(cs, 3), DOC_SPAN_RESET)
        print_verdict();
    end
endmodule : dac_output_calibration_test
